// >>> charger_flag_bank.sv
// status, clear-on-read event flag and interrupt mask registers of the charger
// assumes same-clock status inputs from the charger core and a byte register port
// Functional notes
// - select bit picks reverse uvp: 80% of target when 0, fixed 3.3V when 1
// - max power input voltage in bits 13:2, 20mV steps, clamped, zero after reset
// - sixteen-bit max power value: high byte at upper address, low byte at lower
// - conversion-done status bit 7 reports completion only in one-shot mode
// - bit 6 input current loop active, bit 5 input voltage or reverse loop active
// - watchdog status bit 3 shows timer expired, resets to 1
// - three-bit charge state passed with its documented codes
// - input good status bit 7, resets to 1
// - thermistor region field bits 6:4 with five documented codes
// - power tracking state field bits 1:0
// - sync clock state field bits 5:4
// - bit 3 constant voltage timer expired, bit 2 reverse mode active
// - bit 1 input switch on resets 1, bit 0 battery switch on resets 0
// - fault status shows live protection states in bits 7,6,5,4,3,1
// - gate supply fault reads 1 when battery-only with converter sampling disabled
// - every event flag is read-only and clears when its register is read
// - conversion-done flag only set in one-shot, reads 0 when continuous
// - watchdog and cv timer flags set on rising edge; watchdog flag resets 1
// - charge, thermistor, tracking and sync flags set on any field change
// - input good, switch and reverse flags set on toggle; first three reset 1
// - fault flags set on fault entry; gate supply flag resets to 1
// - mask one bits 7,6,5,3 suppress done, current, voltage, watchdog pulses
// - mask one bits 1,0 suppress cv timer and charge state pulses
// - mask two suppresses input good, switch, thermistor, reverse, sync pulses
// - fault mask suppresses per-fault interrupt pulses
`timescale 1ns/1ps
`include "charger_flags_cfg.svh"

module charger_flag_bank
	import charger_flags_pkg::*;
(
	input  wire logic         CORE_CLK,
	input  wire logic         RESET_N,
	input  wire logic [7:0]   REG_ADDR,
	input  wire logic         REG_WR,
	input  wire logic [7:0]   REG_WDATA,
	input  wire logic         REG_RD,
	output logic      [7:0]   REG_RDATA,
	output logic              REVERSE_SYSTEM_UVP_SELECT,
	output logic              INT_N,
	input  wire logic         ADC_ONE_SHOT,
	input  wire logic         ADC_ENABLED,
	input  wire logic         ADC_CONVERSION_DONE,
	input  wire logic         INPUT_CURRENT_LOOP_STATUS,
	input  wire logic         INPUT_VOLTAGE_LOOP_STATUS,
	input  wire logic         WATCHDOG_EXPIRED_STATUS,
	input  wire logic [2:0]   CHARGE_STATE,
	input  wire logic         INPUT_GOOD_STATUS,
	input  wire logic [2:0]   THERMISTOR_REGION,
	input  wire logic [1:0]   POWER_TRACKING_STATE,
	input  wire logic [1:0]   SYNC_CLOCK_STATE,
	input  wire logic         CONST_VOLTAGE_TIMER_EXPIRED,
	input  wire logic         REVERSE_MODE_ACTIVE,
	input  wire logic         INPUT_SWITCH_ON,
	input  wire logic         BATTERY_SWITCH_ON,
	input  wire logic         BATTERY_ONLY,
	input  wire logic         INPUT_UNDERVOLTAGE,
	input  wire logic         INPUT_OVERVOLTAGE,
	input  wire logic         BATTERY_OVERCURRENT,
	input  wire logic         BATTERY_OVERVOLTAGE,
	input  wire logic         THERMAL_SHUTDOWN_STATUS,
	input  wire logic         GATE_SUPPLY_FAULT_STATUS,
	input  wire logic [11:0]  MAX_POWER_INPUT_VOLTAGE
);

	// ======================================================================
	// register storage
	byte_t        rev_uv_q;
	byte_t        stat1_q;
	byte_t        stat2_q;
	byte_t        stat3_q;
	byte_t        fault_q;
	byte_t        flag1_q;
	byte_t        flag2_q;
	byte_t        fflag_q;
	byte_t        mask1_q;
	byte_t        mask2_q;
	byte_t        fmask_q;
	logic [15:0]  maxpwr_q;
	byte_t        maxpwr_hi_q;
	byte_t        rdata_q;
	pulse_cnt_t   pulse_cnt_q;
	pulse_cnt_t   pulse_cnt_d;

	// ======================================================================
	// address decode
	wire          rd_flag1   = REG_RD && (REG_ADDR == `ADDR_FLAGS_ONE);
	wire          rd_flag2   = REG_RD && (REG_ADDR == `ADDR_FLAGS_TWO);
	wire          rd_fflag   = REG_RD && (REG_ADDR == `ADDR_FAULT_FLAGS);
	wire          rd_mp_lo   = REG_RD && (REG_ADDR == `ADDR_MAXPWR_LO);
	wire          wr_rev_uv  = REG_WR && (REG_ADDR == `ADDR_REV_UV);
	wire          wr_mask1   = REG_WR && (REG_ADDR == `ADDR_MASK_ONE);
	wire          wr_mask2   = REG_WR && (REG_ADDR == `ADDR_MASK_TWO);
	wire          wr_fmask   = REG_WR && (REG_ADDR == `ADDR_FAULT_MASK);

	// ======================================================================
	// live status images
	wire          done_live  = ADC_CONVERSION_DONE && ADC_ONE_SHOT;
	wire          gate_live  = GATE_SUPPLY_FAULT_STATUS
	                           || (BATTERY_ONLY && !ADC_ENABLED);
	wire byte_t   stat1_d    = {done_live, INPUT_CURRENT_LOOP_STATUS,
	                            INPUT_VOLTAGE_LOOP_STATUS, 1'b0,
	                            WATCHDOG_EXPIRED_STATUS, CHARGE_STATE};
	wire byte_t   stat2_d    = {INPUT_GOOD_STATUS, THERMISTOR_REGION, 2'b00,
	                            POWER_TRACKING_STATE};
	wire byte_t   stat3_d    = {2'b00, SYNC_CLOCK_STATE, CONST_VOLTAGE_TIMER_EXPIRED,
	                            REVERSE_MODE_ACTIVE, INPUT_SWITCH_ON,
	                            BATTERY_SWITCH_ON};
	wire byte_t   fault_d    = {INPUT_UNDERVOLTAGE, INPUT_OVERVOLTAGE,
	                            BATTERY_OVERCURRENT, BATTERY_OVERVOLTAGE,
	                            THERMAL_SHUTDOWN_STATUS, 1'b0, gate_live,
	                            1'b0};
	wire          mp_over    = MAX_POWER_INPUT_VOLTAGE > `MAXPWR_CLAMP;
	wire maxpwr_code_t mp_code = mp_over ? `MAXPWR_CLAMP
	                                     : MAX_POWER_INPUT_VOLTAGE;
	wire [15:0]   maxpwr_d   = {2'b00, mp_code, 2'b00};

	// ======================================================================
	// event detection against the previous status
	wire byte_t   ev1 = {stat1_d[7] & ~stat1_q[7],
	                     stat1_d[6] & ~stat1_q[6],
	                     stat1_d[5] & ~stat1_q[5],
	                     1'b0,
	                     stat1_d[3] & ~stat1_q[3],
	                     1'b0,
	                     stat3_d[3] & ~stat3_q[3],
	                     stat1_d[2:0] != stat1_q[2:0]};
	wire byte_t   ev2 = {stat2_d[7] ^ stat2_q[7],
	                     stat3_d[1] ^ stat3_q[1],
	                     stat3_d[0] ^ stat3_q[0],
	                     stat2_d[6:4] != stat2_q[6:4],
	                     stat3_d[2] ^ stat3_q[2],
	                     1'b0,
	                     stat3_d[5:4] != stat3_q[5:4],
	                     stat2_d[1:0] != stat2_q[1:0]};
	wire byte_t   evf = fault_d & ~fault_q & `LIVE_FAULT_BITS;
	wire byte_t   cont_clr = byte_t'(!ADC_ONE_SHOT) << `DONE_BIT;

	// set wins over the clear-on-read
	wire byte_t   flag1_d = ((flag1_q & ~{8{rd_flag1}}) | ev1) & ~cont_clr;
	wire byte_t   flag2_d = (flag2_q & ~{8{rd_flag2}}) | ev2;
	wire byte_t   fflag_d = (fflag_q & ~{8{rd_fflag}}) | evf;

	// ======================================================================
	// interrupt request: unmasked clear-to-set transitions
	wire byte_t   hit1 = ev1 & ~flag1_q & ~mask1_q & ~cont_clr;
	wire byte_t   hit2 = ev2 & ~flag2_q & ~mask2_q;
	wire byte_t   hitf = evf & ~fflag_q & ~fmask_q;
	wire          irq_hit = |{hit1, hit2, hitf};
	wire          int_active = pulse_cnt_q != 8'h00;

	always_comb
	begin
		pulse_cnt_d = pulse_cnt_q;
		if (irq_hit)
			pulse_cnt_d = `INT_PULSE_CYC;
		else if (int_active)
			pulse_cnt_d = pulse_cnt_q - 8'h01;
	end

	// ======================================================================
	// read selection
	wire byte_t   rd_mux =
		(REG_ADDR == `ADDR_REV_UV)       ? rev_uv_q :
		(REG_ADDR == `ADDR_MAXPWR_LO)    ? maxpwr_q[7:0] :
		(REG_ADDR == `ADDR_MAXPWR_HI)    ? maxpwr_hi_q :
		(REG_ADDR == `ADDR_STATUS_ONE)   ? stat1_q :
		(REG_ADDR == `ADDR_STATUS_TWO)   ? stat2_q :
		(REG_ADDR == `ADDR_STATUS_THREE) ? stat3_q :
		(REG_ADDR == `ADDR_FAULT_STATUS) ? fault_q :
		(REG_ADDR == `ADDR_FLAGS_ONE)    ? flag1_q :
		(REG_ADDR == `ADDR_FLAGS_TWO)    ? flag2_q :
		(REG_ADDR == `ADDR_FAULT_FLAGS)  ? fflag_q :
		(REG_ADDR == `ADDR_MASK_ONE)     ? mask1_q :
		(REG_ADDR == `ADDR_MASK_TWO)     ? mask2_q :
		(REG_ADDR == `ADDR_FAULT_MASK)   ? fmask_q : 8'h00;

	// ======================================================================
	// status and flag registers
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			stat1_q  <= `RST_STATUS_ONE;
			stat2_q  <= `RST_STATUS_TWO;
			stat3_q  <= `RST_STATUS_THREE;
			fault_q  <= `RST_FAULT_STATUS;
			maxpwr_q <= `RST_MAXPWR;
			flag1_q  <= `RST_FLAGS_ONE;
			flag2_q  <= `RST_FLAGS_TWO;
			fflag_q  <= `RST_FAULT_FLAGS;
		end
		else
		begin
			stat1_q  <= stat1_d;
			stat2_q  <= stat2_d;
			stat3_q  <= stat3_d;
			fault_q  <= fault_d;
			maxpwr_q <= maxpwr_d;
			flag1_q  <= flag1_d;
			flag2_q  <= flag2_d;
			fflag_q  <= fflag_d;
		end
	end

	// ======================================================================
	// host-writable registers
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			rev_uv_q <= `RST_REV_UV;
			mask1_q  <= `RST_MASK;
			mask2_q  <= `RST_MASK;
			fmask_q  <= `RST_MASK;
		end
		else
		begin
			if (wr_rev_uv)
				rev_uv_q <= REG_WDATA & `WMASK_REV_UV;
			if (wr_mask1)
				mask1_q <= REG_WDATA & `WMASK_MASK_ONE;
			if (wr_mask2)
				mask2_q <= REG_WDATA & `WMASK_MASK_TWO;
			if (wr_fmask)
				fmask_q <= REG_WDATA & `WMASK_FAULT_MASK;
		end
	end

	// ======================================================================
	// read data, high-byte latch and interrupt pulse
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			rdata_q     <= 8'h00;
			maxpwr_hi_q <= 8'h00;
			pulse_cnt_q <= 8'h00;
		end
		else
		begin
			if (REG_RD)
				rdata_q <= rd_mux;
			if (rd_mp_lo)
				maxpwr_hi_q <= maxpwr_q[15:8];
			pulse_cnt_q <= pulse_cnt_d;
		end
	end

	assign REG_RDATA                 = rdata_q;
	assign REVERSE_SYSTEM_UVP_SELECT = rev_uv_q[`REV_UV_SEL_BIT];
	assign INT_N                     = !int_active;

	// ======================================================================
	// checks
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RESET_N);

	chk_uvp_select_write: assert property (
		wr_rev_uv |=> REVERSE_SYSTEM_UVP_SELECT == $past(REG_WDATA[`REV_UV_SEL_BIT]))
		else $error("uvp select does not follow write");

	chk_maxpwr_clamp: assert property (
		maxpwr_q[13:2] <= `MAXPWR_CLAMP && maxpwr_q[15:14] == 2'b00
		&& maxpwr_q[1:0] == 2'b00)
		else $error("max power field out of range");

	chk_maxpwr_pairing: assert property (
		rd_mp_lo |=> maxpwr_hi_q == $past(maxpwr_q[15:8]))
		else $error("high byte not latched on low byte read");

	chk_done_continuous: assert property (
		!ADC_ONE_SHOT |=> !flag1_q[7] && !stat1_q[7])
		else $error("done bit set in continuous mode");

	chk_watchdog_rise: assert property (
		$rose(stat1_q[3]) |-> flag1_q[3])
		else $error("watchdog rise did not set flag");

	chk_charge_change: assert property (
		$changed(stat1_q[2:0]) |-> flag1_q[0])
		else $error("charge state change did not set flag");

	chk_good_toggle: assert property (
		$changed(stat2_q[7]) |-> flag2_q[7])
		else $error("input good toggle did not set flag");

	chk_switch_toggle: assert property (
		$changed(stat3_q[1]) |-> flag2_q[6])
		else $error("input switch toggle did not set flag");

	chk_gate_entry: assert property (
		$rose(fault_q[1]) |-> fflag_q[1])
		else $error("gate supply entry did not set flag");

	chk_undervolt_entry: assert property (
		$rose(fault_q[7]) |-> fflag_q[7])
		else $error("input undervoltage entry did not set flag");

	chk_flag_sticky: assert property (
		!rd_fflag |=> (fflag_q & $past(fflag_q)) == $past(fflag_q))
		else $error("fault flag cleared without a read");

	chk_battery_only_gate: assert property (
		BATTERY_ONLY && !ADC_ENABLED |=> fault_q[1])
		else $error("gate fault not forced in battery-only mode");

	chk_read_clears: assert property (
		rd_flag1 && ev1 == 8'h00 |=> flag1_q == 8'h00)
		else $error("flags one not cleared by read");

	chk_set_wins: assert property (
		rd_flag2 && ev2 != 8'h00 |=> (flag2_q & $past(ev2)) == $past(ev2))
		else $error("event lost during clearing read");

	chk_pulse_length: assert property (
		irq_hit |=> !INT_N && pulse_cnt_q == `INT_PULSE_CYC)
		else $error("interrupt pulse not started");

	chk_pulse_end: assert property (
		pulse_cnt_q == 8'h01 && !irq_hit |=> INT_N)
		else $error("interrupt pulse did not end");

	chk_pulse_count: assert property (
		int_active && !irq_hit |=> pulse_cnt_q == $past(pulse_cnt_q) - 8'h01)
		else $error("interrupt pulse count did not step down");

	chk_all_masked: assert property (
		mask1_q == `WMASK_MASK_ONE && mask2_q == `WMASK_MASK_TWO
		&& fmask_q == `WMASK_FAULT_MASK |-> !irq_hit)
		else $error("masked event raised interrupt");

	cov_flag_read_clear: cover property (flag1_q != 8'h00 ##0 rd_flag1);
	cov_int_pulse:       cover property ($fell(INT_N));
	cov_pair_read:       cover property (rd_mp_lo ##[1:4] REG_RD
	                                     && REG_ADDR == `ADDR_MAXPWR_HI);
	cov_set_on_read:     cover property (rd_fflag && evf != 8'h00);

endmodule

// >>> charger_flags_cfg.svh
// constants for the charger status, event flag and mask register bank
// assumes a byte-wide register port behind the serial host interface
`ifndef CHARGER_FLAGS_CFG_SVH
`define CHARGER_FLAGS_CFG_SVH

// ==========================================================================
// register byte addresses
`define ADDR_REV_UV        8'h1e
`define ADDR_MAXPWR_LO     8'h1f
`define ADDR_MAXPWR_HI     8'h20
`define ADDR_STATUS_ONE    8'h21
`define ADDR_STATUS_TWO    8'h22
`define ADDR_STATUS_THREE  8'h23
`define ADDR_FAULT_STATUS  8'h24
`define ADDR_FLAGS_ONE     8'h25
`define ADDR_FLAGS_TWO     8'h26
`define ADDR_FAULT_FLAGS   8'h27
`define ADDR_MASK_ONE      8'h28
`define ADDR_MASK_TWO      8'h29
`define ADDR_FAULT_MASK    8'h2a

// ==========================================================================
// reset values
`define RST_REV_UV         8'h00
`define RST_STATUS_ONE     8'h08
`define RST_STATUS_TWO     8'h80
`define RST_STATUS_THREE   8'h02
`define RST_FAULT_STATUS   8'h00
`define RST_FLAGS_ONE      8'h88
`define RST_FLAGS_TWO      8'he0
`define RST_FAULT_FLAGS    8'h02
`define RST_MASK           8'h00
`define RST_MAXPWR         16'h0000

// ==========================================================================
// writable and live bit sets
`define WMASK_REV_UV       8'h20
`define WMASK_MASK_ONE     8'heb
`define WMASK_MASK_TWO     8'hfa
`define WMASK_FAULT_MASK   8'hfa
`define LIVE_FAULT_BITS    8'hfa

// ==========================================================================
// field positions and limits
`define REV_UV_SEL_BIT     5
`define DONE_BIT           7
`define MAXPWR_CLAMP       12'hbb8

// ==========================================================================
// interrupt pulse timing
`define CLK_PERIOD_NS      25
`define INT_PULSE_NS       1000
`define INT_PULSE_CYC      8'((`INT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> charger_flags_pkg.sv
// types shared by the charger status and flag register bank
// assumes nothing beyond the constants header
package charger_flags_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [11:0] maxpwr_code_t;
	typedef logic [7:0]  pulse_cnt_t;
endpackage

// >>> reg_host.sv
// host model driving the byte register port of the flag bank
// assumes strobes taken on the rising clock edge and read data one cycle later
`timescale 1ns/1ps

module reg_host
(
	input  wire logic       clk,
	output logic      [7:0] addr,
	output logic            wr,
	output logic      [7:0] wdata,
	output logic            rd,
	input  wire logic [7:0] rdata
);
	// ==========================================================================
	// idle levels
	initial
	begin
		addr  = 8'h00;
		wr    = 1'b0;
		wdata = 8'h00;
		rd    = 1'b0;
	end

	// ==========================================================================
	// byte transfers, address and data scrambled once released
	task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		addr  <= ~a;
		wdata <= ~d;
	endtask

	task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		addr <= ~a;
		@(negedge clk);
		d = rdata;
	endtask
endmodule

// >>> tb_top.sv
// self-checking bench for the charger status, event flag and mask bank
// assumes the host model file and the design constants header
`timescale 1ns/1ps
`include "charger_flags_cfg.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end

module tb_top
	import charger_flags_pkg::*;
();
	// ==========================================================================
	// design signals
	logic CORE_CLK, RESET_N, REG_WR, REG_RD, REVERSE_SYSTEM_UVP_SELECT, INT_N;
	logic ADC_ONE_SHOT, ADC_ENABLED, ADC_CONVERSION_DONE, INPUT_CURRENT_LOOP_STATUS;
	logic INPUT_VOLTAGE_LOOP_STATUS, WATCHDOG_EXPIRED_STATUS, INPUT_GOOD_STATUS;
	logic CONST_VOLTAGE_TIMER_EXPIRED, REVERSE_MODE_ACTIVE, INPUT_SWITCH_ON, BATTERY_SWITCH_ON;
	logic BATTERY_ONLY, INPUT_UNDERVOLTAGE, INPUT_OVERVOLTAGE, BATTERY_OVERCURRENT;
	logic BATTERY_OVERVOLTAGE, THERMAL_SHUTDOWN_STATUS, GATE_SUPPLY_FAULT_STATUS;
	logic [2:0] CHARGE_STATE, THERMISTOR_REGION;
	logic [1:0] POWER_TRACKING_STATE, SYNC_CLOCK_STATE;
	byte_t REG_ADDR, REG_WDATA, REG_RDATA, s1, s2, s3, s4, f1, f2, f4, m1, m2, m4, r1e, hi, mexp, d;
	maxpwr_code_t MAX_POWER_INPUT_VOLTAGE, mp;
	int error_cnt, n_compared, icnt, cyc;
	logic rnd_on;
	logic [2:0] cs_tab [5] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6};

	charger_flag_bank u_dut (.CORE_CLK, .RESET_N, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD,
		.REG_RDATA, .REVERSE_SYSTEM_UVP_SELECT, .INT_N, .ADC_ONE_SHOT, .ADC_ENABLED,
		.ADC_CONVERSION_DONE, .INPUT_CURRENT_LOOP_STATUS, .INPUT_VOLTAGE_LOOP_STATUS,
		.WATCHDOG_EXPIRED_STATUS, .CHARGE_STATE, .INPUT_GOOD_STATUS, .THERMISTOR_REGION,
		.POWER_TRACKING_STATE, .SYNC_CLOCK_STATE, .CONST_VOLTAGE_TIMER_EXPIRED,
		.REVERSE_MODE_ACTIVE, .INPUT_SWITCH_ON, .BATTERY_SWITCH_ON, .BATTERY_ONLY,
		.INPUT_UNDERVOLTAGE, .INPUT_OVERVOLTAGE, .BATTERY_OVERCURRENT, .BATTERY_OVERVOLTAGE,
		.THERMAL_SHUTDOWN_STATUS, .GATE_SUPPLY_FAULT_STATUS, .MAX_POWER_INPUT_VOLTAGE);

	reg_host u_host (.clk(CORE_CLK), .addr(REG_ADDR), .wr(REG_WR), .wdata(REG_WDATA),
		.rd(REG_RD), .rdata(REG_RDATA));

	// ==========================================================================
	// behavioural model of the register bank
	wire byte_t i1 = {ADC_CONVERSION_DONE & ADC_ONE_SHOT, INPUT_CURRENT_LOOP_STATUS,
		INPUT_VOLTAGE_LOOP_STATUS, 1'b0, WATCHDOG_EXPIRED_STATUS, CHARGE_STATE};
	wire byte_t i2 = {INPUT_GOOD_STATUS, THERMISTOR_REGION, 2'b00, POWER_TRACKING_STATE};
	wire byte_t i3 = {2'b00, SYNC_CLOCK_STATE, CONST_VOLTAGE_TIMER_EXPIRED, REVERSE_MODE_ACTIVE,
		INPUT_SWITCH_ON, BATTERY_SWITCH_ON};
	wire byte_t i4 = {INPUT_UNDERVOLTAGE, INPUT_OVERVOLTAGE, BATTERY_OVERCURRENT,
		BATTERY_OVERVOLTAGE, THERMAL_SHUTDOWN_STATUS, 1'b0,
		GATE_SUPPLY_FAULT_STATUS | (BATTERY_ONLY & ~ADC_ENABLED), 1'b0};
	wire byte_t c2 = i2 ^ s2;
	wire byte_t c3 = i3 ^ s3;
	wire byte_t e1 = {i1[7:5] & ~s1[7:5], 1'b0, i1[3] & ~s1[3], 1'b0, i3[3] & ~s3[3],
		|(i1[2:0] ^ s1[2:0])};
	wire byte_t e2 = {c2[7], c3[1], c3[0], |c2[6:4], c3[2], 1'b0, |c3[5:4], |c2[1:0]};
	wire byte_t e4 = i4 & ~s4;
	wire logic hit = (|(e1 & ~f1 & ~m1)) | (|(e2 & ~f2 & ~m2)) | (|(e4 & ~f4 & ~m4));
	wire logic rd1 = REG_RD && REG_ADDR == `ADDR_FLAGS_ONE;
	wire logic rd2 = REG_RD && REG_ADDR == `ADDR_FLAGS_TWO;
	wire logic rd4 = REG_RD && REG_ADDR == `ADDR_FAULT_FLAGS;

	function automatic byte_t rd_val(input byte_t a);
		case (a)
			`ADDR_REV_UV:       return r1e;
			`ADDR_MAXPWR_LO:    return {mp[5:0], 2'b00};
			`ADDR_MAXPWR_HI:    return hi;
			`ADDR_STATUS_ONE:   return s1;
			`ADDR_STATUS_TWO:   return s2;
			`ADDR_STATUS_THREE: return s3;
			`ADDR_FAULT_STATUS: return s4;
			`ADDR_FLAGS_ONE:    return f1;
			`ADDR_FLAGS_TWO:    return f2;
			`ADDR_FAULT_FLAGS:  return f4;
			`ADDR_MASK_ONE:     return m1;
			`ADDR_MASK_TWO:     return m2;
			`ADDR_FAULT_MASK:   return m4;
			default:            return 8'h00;
		endcase
	endfunction

	always @(posedge CORE_CLK or negedge RESET_N)
	if (!RESET_N)
	begin
		{s1, s2, s3, s4} <= {`RST_STATUS_ONE, `RST_STATUS_TWO, `RST_STATUS_THREE, 8'h00};
		{f1, f2, f4} <= {`RST_FLAGS_ONE, `RST_FLAGS_TWO, `RST_FAULT_FLAGS};
		{m1, m2, m4, r1e, hi, mexp} <= 48'h0;
		mp <= 12'h000;
		icnt <= 0;
	end
	else
	begin
		{s1, s2, s3, s4} <= {i1, i2, i3, i4};
		mp <= (MAX_POWER_INPUT_VOLTAGE > `MAXPWR_CLAMP) ? `MAXPWR_CLAMP
			: MAX_POWER_INPUT_VOLTAGE;
		f1 <= ((f1 & ~{8{rd1}}) | e1) & {ADC_ONE_SHOT, 7'h7f};
		f2 <= (f2 & ~{8{rd2}}) | e2;
		f4 <= (f4 & ~{8{rd4}}) | e4;
		icnt <= hit ? `INT_PULSE_CYC : (icnt > 0 ? icnt - 1 : 0);
		if (REG_WR && REG_ADDR == `ADDR_MASK_ONE) m1 <= REG_WDATA & `WMASK_MASK_ONE;
		if (REG_WR && REG_ADDR == `ADDR_MASK_TWO) m2 <= REG_WDATA & `WMASK_MASK_TWO;
		if (REG_WR && REG_ADDR == `ADDR_FAULT_MASK) m4 <= REG_WDATA & `WMASK_FAULT_MASK;
		if (REG_WR && REG_ADDR == `ADDR_REV_UV) r1e <= REG_WDATA & `WMASK_REV_UV;
		if (REG_RD) mexp <= rd_val(REG_ADDR);
		if (REG_RD && REG_ADDR == `ADDR_MAXPWR_LO) hi <= {2'b00, mp[11:6]};
	end

	// ==========================================================================
	// clock, timeout, stimulus and checks
	always #12.5 CORE_CLK = ~CORE_CLK;

	always @(posedge CORE_CLK)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			stop_test();
		end
	end

	always @(negedge CORE_CLK)
	if (RESET_N === 1'b1) `CHK("INT_N", icnt == 0, INT_N)

	always @(posedge CORE_CLK)
	if (rnd_on && $urandom_range(5) == 0)
	begin
		{ADC_CONVERSION_DONE, ADC_ENABLED, INPUT_CURRENT_LOOP_STATUS, INPUT_VOLTAGE_LOOP_STATUS,
			WATCHDOG_EXPIRED_STATUS, INPUT_GOOD_STATUS, CONST_VOLTAGE_TIMER_EXPIRED,
			REVERSE_MODE_ACTIVE, INPUT_SWITCH_ON, BATTERY_SWITCH_ON, BATTERY_ONLY,
			INPUT_UNDERVOLTAGE, INPUT_OVERVOLTAGE, BATTERY_OVERCURRENT, BATTERY_OVERVOLTAGE,
			THERMAL_SHUTDOWN_STATUS, GATE_SUPPLY_FAULT_STATUS} <= 17'($urandom);
		CHARGE_STATE <= cs_tab[$urandom_range(4)];
		THERMISTOR_REGION <= 3'($urandom_range(4));
		POWER_TRACKING_STATE <= 2'($urandom);
		SYNC_CLOCK_STATE <= 2'($urandom_range(2));
		MAX_POWER_INPUT_VOLTAGE <= 12'($urandom);
	end

	task automatic rd_chk(input byte_t a);
		u_host.rd_byte(a, d);
		`CHK("REG_RDATA", mexp, d)
	endtask

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		void'($urandom(8735));
		{CORE_CLK, RESET_N, rnd_on, error_cnt, n_compared, cyc} = '0;
		{ADC_ONE_SHOT, ADC_ENABLED, WATCHDOG_EXPIRED_STATUS, INPUT_GOOD_STATUS} = 4'hf;
		INPUT_SWITCH_ON = 1'b1;
		{ADC_CONVERSION_DONE, INPUT_CURRENT_LOOP_STATUS, INPUT_VOLTAGE_LOOP_STATUS} = 3'h0;
		{CONST_VOLTAGE_TIMER_EXPIRED, REVERSE_MODE_ACTIVE, BATTERY_SWITCH_ON, BATTERY_ONLY} = 4'h0;
		{INPUT_UNDERVOLTAGE, INPUT_OVERVOLTAGE, BATTERY_OVERCURRENT} = 3'h0;
		{BATTERY_OVERVOLTAGE, THERMAL_SHUTDOWN_STATUS, GATE_SUPPLY_FAULT_STATUS} = 3'h0;
		{CHARGE_STATE, THERMISTOR_REGION, POWER_TRACKING_STATE, SYNC_CLOCK_STATE} = 10'h000;
		MAX_POWER_INPUT_VOLTAGE = 12'h000;
		repeat (2) @(posedge CORE_CLK);
		RESET_N <= 1'b1;
		rd_chk(`ADDR_MAXPWR_HI);
		for (int k = 0; k < 2; k++)
			for (int a = 8'h1e; a <= 8'h2a; a++) rd_chk(8'(a));
		rd_chk(8'h40);
		u_host.wr_byte(`ADDR_STATUS_ONE, 8'hff);
		rd_chk(`ADDR_STATUS_ONE);
		foreach (cs_tab[k])
		begin
			u_host.wr_byte(8'h1e + 8'(k % 4) + (k > 0 ? 8'h09 : 8'h00), 8'hff);
			rd_chk(8'h1e + 8'(k % 4) + (k > 0 ? 8'h09 : 8'h00));
		end
		`CHK("UVP_SELECT", 1'b1, REVERSE_SYSTEM_UVP_SELECT)
		u_host.wr_byte(`ADDR_REV_UV, 8'h00);
		@(negedge CORE_CLK);
		`CHK("UVP_SELECT", 1'b0, REVERSE_SYSTEM_UVP_SELECT)
		@(posedge CORE_CLK);
		for (int k = 0; k < 2; k++)
		begin
			WATCHDOG_EXPIRED_STATUS <= 1'b0;
			repeat (3) @(posedge CORE_CLK);
			WATCHDOG_EXPIRED_STATUS <= 1'b1;
			repeat (50) @(posedge CORE_CLK);
			rd_chk(`ADDR_FLAGS_ONE);
			u_host.wr_byte(`ADDR_MASK_ONE, 8'h00);
		end
		ADC_ONE_SHOT <= 1'b0;
		@(posedge CORE_CLK);
		ADC_CONVERSION_DONE <= 1'b1;
		repeat (3) @(posedge CORE_CLK);
		rd_chk(`ADDR_STATUS_ONE);
		rd_chk(`ADDR_FLAGS_ONE);
		@(posedge CORE_CLK);
		ADC_CONVERSION_DONE <= 1'b0;
		repeat (3) @(posedge CORE_CLK);
		ADC_ONE_SHOT <= 1'b1;
		MAX_POWER_INPUT_VOLTAGE <= 12'hfff;
		repeat (3) @(posedge CORE_CLK);
		rd_chk(`ADDR_MAXPWR_LO);
		@(posedge CORE_CLK);
		MAX_POWER_INPUT_VOLTAGE <= 12'($urandom);
		repeat (3) @(posedge CORE_CLK);
		rd_chk(`ADDR_MAXPWR_HI);
		rd_chk(`ADDR_MAXPWR_LO);
		rd_chk(`ADDR_MAXPWR_HI);
		rnd_on <= 1'b1;
		repeat (600)
		begin
			automatic byte_t a = 8'h1e + 8'($urandom_range(12));
			if ($urandom_range(3) == 0)
				u_host.wr_byte(a, 8'($urandom));
			else
				rd_chk(a);
		end
		stop_test();
	end
endmodule
